// >>> design/tksc_pkg.sv
package tksc_pkg;

    // -------------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_TRIGGER   = 8'h00;
    localparam logic [7:0] ADDR_CFG_ONE   = 8'h04;
    localparam logic [7:0] ADDR_CFG_TWO   = 8'h08;
    localparam logic [7:0] ADDR_CHAN_SEL  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CTRL  = 8'h10;
    localparam logic [7:0] ADDR_ANALOG    = 8'h14;
    localparam logic [7:0] ADDR_PIN_LOW   = 8'h18;
    localparam logic [7:0] ADDR_PIN_HIGH  = 8'h1C;
    localparam logic [7:0] ADDR_PULLUP    = 8'h20;
    localparam logic [7:0] ADDR_RESULT    = 8'h24;
    localparam logic [7:0] ADDR_CLK_GATES = 8'h40;
    localparam logic [7:0] ADDR_ANA_POWER = 8'h44;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [31:0] RST_CLK_GATES = 32'h0000_0001;
    localparam logic [4:0]  RST_ANA_POWER = 5'h07;
    localparam logic [6:0]  RST_CFG_ONE   = 7'h00;
    localparam logic [6:0]  RST_CFG_TWO   = 7'h70;
    localparam logic [5:0]  RST_ANALOG    = 6'h2F;
    localparam logic [8:0]  RST_PULLUP    = 9'h100;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int POS_TOUCH_CLK_GATE = 19;
    localparam int POS_PD_TOUCH       = 1;
    localparam int POS_SW_PRE_OFF     = 6;
    localparam int POS_COUNTER_WIDTH_SEL_LSB       = 4;
    localparam int POS_DS_LSB         = 2;
    localparam int POS_PARALLEL       = 6;
    localparam int POS_IRQ_CLEAR      = 2;
    localparam int POS_IRQ_STAT       = 1;
    localparam int POS_IRQ_EN         = 0;
    localparam int POS_BIAS_LSB       = 3;

    // -------------------------------------------------------------------
    // Timing counts in reference clock cycles
    // -------------------------------------------------------------------
    localparam logic [6:0] DIV_OFFSET    = 7'h04;  // Half period = code + 4
    localparam logic [5:0] DIV_PRS_NORM  = 6'h3E;
    localparam logic [5:0] DIV_PRS_FLAT  = 6'h3F;
    localparam logic [6:0] PRS_MIN_HALF  = 7'h08;  // 3M edge of spread band
    localparam logic [6:0] PRS_NORM_BASE = 7'h09;  // Two dice, centre 16 -> 1.5M
    localparam logic [4:0] COUNTER_WIDTH_SEL_BASE     = 5'h09;
    localparam logic [3:0] CNT_DIV_24M   = 4'h2;
    localparam logic [3:0] CNT_DIV_12M   = 4'h4;
    localparam logic [3:0] CNT_DIV_6M    = 4'h8;
    localparam logic [3:0] CNT_DIV_4M    = 4'hC;
    localparam logic [15:0] LFSR_SEED    = 16'hACE1;

    // -------------------------------------------------------------------
    // Analog front-end control bundle
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [59:0] pin_sel;
        logic [5:0]  chan_addr;
        logic        parallel_en;
        logic [8:0]  pullup_sel;
        logic [2:0]  bias_resistor_sel;
        logic [2:0]  threshold_voltage_sel;
        logic        front_end_on;
        logic        charge_clk;
        logic        scan_active;
    } tksc_afe_t;

endpackage

// >>> design/tksc_touch_scanner.sv
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module tksc_touch_scanner #(
    parameter int MAX_COUNT_W = 16
) (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               sense_cmp,
    output tksc_pkg::tksc_afe_t     afe_ctrl,
    output logic                    irq,
    output logic                    wake_pulse
);

    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    typedef enum logic [0:0] {TKSC_IDLE, TKSC_RUN} tksc_state_t;

    tksc_state_t  state_ff;
    logic         ack_ff;
    logic [31:0]  rdata_ff;
    logic [31:0]  clk_gates_ff;
    logic [4:0]   ana_power_ff;
    logic [6:0]   cfg_one_ff;
    logic [6:0]   cfg_two_ff;
    logic [6:0]   chan_sel_ff;
    logic         irq_en_ff;
    logic         done_stat_ff;
    logic [5:0]   analog_ff;
    logic [31:0]  pin_low_ff;
    logic [27:0]  pin_high_ff;
    logic [8:0]   pullup_ff;
    logic [15:0]  result_ff;
    logic         trigger_ff;
    logic         cmp_meta_ff;
    logic         cmp_sync_ff;
    logic [6:0]   half_cnt_ff;
    logic         charge_clk_ff;
    logic [15:0]  lfsr_ff;
    logic [3:0]   tick_cnt_ff;
    logic [15:0]  window_ff;
    logic [15:0]  count_ff;
    logic         wake_ff;

    logic         wr_go;
    logic [31:0]  wr_word;
    logic [31:0]  rd_word;
    logic         module_on;
    logic         scan_done;
    logic         start_req;
    logic         abort_req;
    logic [6:0]   nxt_half;
    logic [3:0]   tick_div;
    logic         count_tick;
    logic [15:0]  window_full;
    logic [4:0]   counter_w;

    // -------------------------------------------------------------------
    // Elaboration check
    // -------------------------------------------------------------------
    if (MAX_COUNT_W != 16) begin : g_width_check
        $error("tksc_touch_scanner: MAX_COUNT_W must be 16");
    end

    // -------------------------------------------------------------------
    // Wishbone slave
    // -------------------------------------------------------------------
    // Write lands on the edge that samples ack, so the held request is final
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;

    // Byte-lane merge of write data onto the current register value
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Read mux; unmapped addresses answer with zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (wb_adr_i)
            tksc_pkg::ADDR_TRIGGER:   rd_word = {31'h0000_0000, trigger_ff};
            tksc_pkg::ADDR_CFG_ONE:   rd_word = {25'h000_0000, cfg_one_ff};
            tksc_pkg::ADDR_CFG_TWO:   rd_word = {25'h000_0000, cfg_two_ff};
            tksc_pkg::ADDR_CHAN_SEL:  rd_word = {25'h000_0000, chan_sel_ff};
            tksc_pkg::ADDR_IRQ_CTRL:  rd_word = {30'h0000_0000, done_stat_ff, irq_en_ff};
            tksc_pkg::ADDR_ANALOG:    rd_word = {26'h000_0000, analog_ff};
            tksc_pkg::ADDR_PIN_LOW:   rd_word = pin_low_ff;
            tksc_pkg::ADDR_PIN_HIGH:  rd_word = {4'h0, pin_high_ff};
            tksc_pkg::ADDR_PULLUP:    rd_word = {23'h00_0000, pullup_ff};
            tksc_pkg::ADDR_RESULT:    rd_word = {16'h0000, result_ff};
            tksc_pkg::ADDR_CLK_GATES: rd_word = clk_gates_ff;
            tksc_pkg::ADDR_ANA_POWER: rd_word = {27'h000_0000, ana_power_ff};
            default:                  rd_word = 32'h0000_0000;
        endcase
    end

    assign wr_word = merge_lanes(rd_word, wb_dat_i, wb_sel_i);

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
            if (wb_cyc_i && wb_stb_i && !ack_ff) begin
                rdata_ff <= rd_word;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    // -------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------
    // Plain read/write storage; reserved bits are simply not kept
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_gates_ff <= tksc_pkg::RST_CLK_GATES;
            ana_power_ff <= tksc_pkg::RST_ANA_POWER;
            cfg_one_ff   <= tksc_pkg::RST_CFG_ONE;
            cfg_two_ff   <= tksc_pkg::RST_CFG_TWO;
            chan_sel_ff  <= 7'h00;
            irq_en_ff    <= 1'b0;
            analog_ff    <= tksc_pkg::RST_ANALOG;
            pin_low_ff   <= 32'h0000_0000;
            pin_high_ff  <= 28'h000_0000;
            pullup_ff    <= tksc_pkg::RST_PULLUP;
        end else if (wr_go) begin
            unique case (wb_adr_i)
                tksc_pkg::ADDR_CLK_GATES: clk_gates_ff <= wr_word;
                tksc_pkg::ADDR_ANA_POWER: ana_power_ff <= wr_word[4:0];
                tksc_pkg::ADDR_CFG_ONE:   cfg_one_ff   <= wr_word[6:0];
                tksc_pkg::ADDR_CFG_TWO:   cfg_two_ff   <= wr_word[6:0];
                tksc_pkg::ADDR_CHAN_SEL:  chan_sel_ff  <= wr_word[6:0];
                tksc_pkg::ADDR_IRQ_CTRL:  irq_en_ff    <= wr_word[tksc_pkg::POS_IRQ_EN];
                tksc_pkg::ADDR_ANALOG:    analog_ff    <= wr_word[5:0];
                tksc_pkg::ADDR_PIN_LOW:   pin_low_ff   <= wr_word;
                tksc_pkg::ADDR_PIN_HIGH:  pin_high_ff  <= wr_word[27:0];
                tksc_pkg::ADDR_PULLUP:    pullup_ff    <= wr_word[8:0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Scan control
    // -------------------------------------------------------------------
    // Module runs only with its clock gate set and the front end powered
    assign module_on = clk_gates_ff[tksc_pkg::POS_TOUCH_CLK_GATE] &&
                       !ana_power_ff[tksc_pkg::POS_PD_TOUCH];

    assign start_req = wr_go && (wb_adr_i == tksc_pkg::ADDR_TRIGGER) &&
                       wb_sel_i[0] && wb_dat_i[0];
    assign abort_req = (wr_go && (wb_adr_i == tksc_pkg::ADDR_TRIGGER) &&
                        wb_sel_i[0] && !wb_dat_i[0]) || !module_on;

    assign counter_w   = tksc_pkg::COUNTER_WIDTH_SEL_BASE +
                         {2'b00, cfg_two_ff[tksc_pkg::POS_COUNTER_WIDTH_SEL_LSB +: 3]};
    assign window_full = 16'((32'h1 << counter_w) - 32'h1);
    assign scan_done   = (state_ff == TKSC_RUN) && count_tick &&
                         (window_ff == window_full) && !abort_req;

    // Trigger bit tracks the scan: set by software, cleared at the end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= TKSC_IDLE;
            trigger_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                TKSC_IDLE: begin
                    if (start_req && module_on) begin
                        state_ff   <= TKSC_RUN;
                        trigger_ff <= 1'b1;
                    end
                end
                TKSC_RUN: begin
                    if (abort_req) begin
                        state_ff   <= TKSC_IDLE;
                        trigger_ff <= 1'b0;
                    end else if (scan_done) begin
                        state_ff   <= TKSC_IDLE;
                        trigger_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Comparator synchroniser
    // -------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta_ff <= 1'b0;
            cmp_sync_ff <= 1'b0;
        end else begin
            cmp_meta_ff <= sense_cmp;
            cmp_sync_ff <= cmp_meta_ff;
        end
    end

    // -------------------------------------------------------------------
    // Charge/discharge clock
    // -------------------------------------------------------------------
    // Spread codes draw the half period from an LFSR to smear pad noise
    always_comb begin
        if (cfg_one_ff[5:0] == tksc_pkg::DIV_PRS_NORM) begin
            nxt_half = tksc_pkg::PRS_NORM_BASE + {4'h0, lfsr_ff[2:0]} +
                       {4'h0, lfsr_ff[6:4]};
        end else if (cfg_one_ff[5:0] == tksc_pkg::DIV_PRS_FLAT) begin
            nxt_half = tksc_pkg::PRS_MIN_HALF + {3'h0, lfsr_ff[3:0]};
        end else begin
            nxt_half = {1'b0, cfg_one_ff[5:0]} + tksc_pkg::DIV_OFFSET;
        end
    end

    // Held idle outside a scan so every scan starts from the same phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            half_cnt_ff   <= 7'h01;
            charge_clk_ff <= 1'b0;
        end else if (state_ff != TKSC_RUN || abort_req) begin
            half_cnt_ff   <= 7'h01;
            charge_clk_ff <= 1'b0;
        end else if (half_cnt_ff >= nxt_half) begin
            half_cnt_ff   <= 7'h01;
            charge_clk_ff <= !charge_clk_ff;
        end else begin
            half_cnt_ff <= half_cnt_ff + 7'h01;
        end
    end

    // Free-running LFSR; it only steers timing, never data
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_ff <= tksc_pkg::LFSR_SEED;
        end else begin
            lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^
                        lfsr_ff[12] ^ lfsr_ff[10]};
        end
    end

    // -------------------------------------------------------------------
    // Count clock and counters
    // -------------------------------------------------------------------
    always_comb begin
        unique case (cfg_two_ff[tksc_pkg::POS_DS_LSB +: 2])
            2'b00: tick_div = tksc_pkg::CNT_DIV_24M;
            2'b01: tick_div = tksc_pkg::CNT_DIV_12M;
            2'b10: tick_div = tksc_pkg::CNT_DIV_6M;
            2'b11: tick_div = tksc_pkg::CNT_DIV_4M;
        endcase
    end

    assign count_tick = (state_ff == TKSC_RUN) && (tick_cnt_ff == tick_div - 4'h1);

    // Window length scales with both resolution and count speed
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= 4'h0;
            window_ff   <= 16'h0000;
            count_ff    <= 16'h0000;
        end else if (state_ff != TKSC_RUN || abort_req) begin
            tick_cnt_ff <= 4'h0;
            window_ff   <= 16'h0000;
            count_ff    <= 16'h0000;
        end else begin
            tick_cnt_ff <= count_tick ? 4'h0 : tick_cnt_ff + 4'h1;
            if (count_tick) begin
                window_ff <= window_ff + 16'h0001;
                if (cmp_sync_ff) begin
                    count_ff <= count_ff + 16'h0001;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Result, done flag and wake
    // -------------------------------------------------------------------
    // Set wins over a same-cycle software clear so no completion is lost
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            result_ff    <= 16'h0000;
            done_stat_ff <= 1'b0;
            wake_ff      <= 1'b0;
        end else begin
            wake_ff <= scan_done;
            if (scan_done) begin
                result_ff    <= count_ff + {15'h0000, cmp_sync_ff};
                done_stat_ff <= 1'b1;
            end else if (wr_go && (wb_adr_i == tksc_pkg::ADDR_IRQ_CTRL) &&
                         wb_sel_i[0] && wb_dat_i[tksc_pkg::POS_IRQ_CLEAR]) begin
                done_stat_ff <= 1'b0;
            end
        end
    end

    assign irq        = done_stat_ff && irq_en_ff;
    assign wake_pulse = wake_ff;

    // -------------------------------------------------------------------
    // Front-end control outputs
    // -------------------------------------------------------------------
    always_comb begin
        afe_ctrl.pin_sel               = {pin_high_ff, pin_low_ff};
        afe_ctrl.chan_addr             = chan_sel_ff[5:0];
        afe_ctrl.parallel_en           = chan_sel_ff[tksc_pkg::POS_PARALLEL];
        afe_ctrl.pullup_sel            = pullup_ff;
        afe_ctrl.bias_resistor_sel     = analog_ff[tksc_pkg::POS_BIAS_LSB +: 3];
        afe_ctrl.threshold_voltage_sel = analog_ff[2:0];
        afe_ctrl.front_end_on          = module_on;
        afe_ctrl.charge_clk            = charge_clk_ff &&
                                         !cfg_one_ff[tksc_pkg::POS_SW_PRE_OFF];
        afe_ctrl.scan_active           = (state_ff == TKSC_RUN);
    end

endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // -----------------------------------------------------------------
    // Stimulus and checking
    // -----------------------------------------------------------------
    logic                mclk, rst_n, cyc, stb, we, ack, cmp, irq, wake, touched;
    logic [7:0]          adr;
    logic [3:0]          sel;
    logic [31:0]         wdat, wdo, rd;
    tksc_pkg::tksc_afe_t afe;
    int                  err_total, n_checks, cyc_cnt;
    tksc_touch_scanner #(.MAX_COUNT_W(16)) uut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wdo), .wb_ack_o(ack), .sense_cmp(cmp), .afe_ctrl(afe), .irq(irq),
        .wake_pulse(wake));
    tksc_pad_model pad (.afe_ctrl(afe), .mclk(mclk), .touched(touched), .sense_cmp(cmp));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Hang guard well above the longest expected run
    always @(posedge mclk) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            err_total++;
            $display("[FAIL] %0t timeout", $time);
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        n_checks++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("[FAIL] %0t %s %0d not in %0d..%0d", $time, what, got, lo, hi);
        end
    endtask
    // Classic single cycle: hold until ack, take data at that edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        t = 0;
        do begin
            @(posedge mclk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        if (t >= 50) chk(32'h0, 32'h1, "no ack");
        rd = wdo;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp, "register read");
    endtask
    // Full scan: length, result, self-clearing trigger, done flag and irq
    task automatic run_scan(input int counter_width_sel, input int ds, input logic lvl);
        int n, tk, ln;
        tk = (ds == 3) ? 12 : (2 << ds);
        ln = (512 << counter_width_sel) * tk;
        touched <= lvl;
        wr(tksc_pkg::ADDR_CFG_TWO, 32'((counter_width_sel << 4) | (ds << 2)));
        wr(tksc_pkg::ADDR_TRIGGER, 32'h1);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (afe.scan_active === 1'b1 && n < 20000);
        chk_rng(n, ln - tk - 2, ln + tk + 2, "scan length");
        chk(32'(wake), 32'h1, "wake pulse");
        rd_chk(tksc_pkg::ADDR_TRIGGER, 32'h0);
        rd_chk(tksc_pkg::ADDR_RESULT, lvl ? 32'(512 << counter_width_sel) : 32'h0);
        rd_chk(tksc_pkg::ADDR_IRQ_CTRL, 32'h3);
        chk(32'(irq), 32'h1, "irq set");
        wr(tksc_pkg::ADDR_IRQ_CTRL, 32'h1);
        rd_chk(tksc_pkg::ADDR_IRQ_CTRL, 32'h3);
        wr(tksc_pkg::ADDR_IRQ_CTRL, 32'h5);
        rd_chk(tksc_pkg::ADDR_IRQ_CTRL, 32'h1);
        chk(32'(irq), 32'h0, "irq cleared");
    endtask
    // Measure charge clock half periods, then abort the scan
    task automatic chk_div(input logic [5:0] code, input int lo, input int hi);
        int n, k;
        logic p;
        wr(tksc_pkg::ADDR_CFG_TWO, 32'h70);
        wr(tksc_pkg::ADDR_CFG_ONE, 32'(code));
        wr(tksc_pkg::ADDR_TRIGGER, 32'h1);
        for (k = 0; k < 5; k++) begin
            p = afe.charge_clk;
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (afe.charge_clk === p && n < 200);
            if (k > 0) chk_rng(n, lo, hi, "half period");
        end
        wr(tksc_pkg::ADDR_TRIGGER, 32'h0);
        @(posedge mclk);
        chk(32'(afe.scan_active), 32'h0, "abort");
        rd_chk(tksc_pkg::ADDR_IRQ_CTRL, 32'h1);
    endtask
    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        touched = 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(tksc_pkg::ADDR_CLK_GATES, tksc_pkg::RST_CLK_GATES);
        rd_chk(tksc_pkg::ADDR_CFG_TWO, 32'h70);
        rd_chk(tksc_pkg::ADDR_ANALOG, 32'h2F);
        rd_chk(tksc_pkg::ADDR_PULLUP, 32'h100);
        rd_chk(tksc_pkg::ADDR_ANA_POWER, 32'h07);
        wr(8'h80, 32'hFFFF_FFFF);
        rd_chk(8'h80, 32'h0);
        wr(tksc_pkg::ADDR_TRIGGER, 32'h1);
        rd_chk(tksc_pkg::ADDR_TRIGGER, 32'h0);
        wr(tksc_pkg::ADDR_CLK_GATES, 32'h0008_0001);
        wr(tksc_pkg::ADDR_ANA_POWER, 32'h05);
        wr(tksc_pkg::ADDR_CHAN_SEL, 32'h7B);
        wr(tksc_pkg::ADDR_PULLUP, 32'h1FF);
        wr(tksc_pkg::ADDR_PIN_HIGH, 32'h0800_0001);
        wr(tksc_pkg::ADDR_ANALOG, 32'h1A);
        // Register outputs settle after the write edge, so look one edge later
        @(posedge mclk);
        chk(32'(afe.front_end_on), 32'h1, "front end on");
        chk(32'(afe.pin_sel[59:32]), 32'h0800_0001, "pins");
        chk(32'({afe.parallel_en, afe.chan_addr}), 32'h7B, "channel");
        chk(32'(afe.pullup_sel), 32'h1FF, "pull-up code");
        chk(32'({afe.bias_resistor_sel, afe.threshold_voltage_sel}), 32'h1A, "analog");
        sel <= 4'h2;
        wr(tksc_pkg::ADDR_PULLUP, 32'h0);
        sel <= 4'hF;
        rd_chk(tksc_pkg::ADDR_PULLUP, 32'h0FF);
        wr(tksc_pkg::ADDR_RESULT, 32'hFFFF);
        rd_chk(tksc_pkg::ADDR_RESULT, 32'h0);
        wr(tksc_pkg::ADDR_IRQ_CTRL, 32'h1);
        wr(tksc_pkg::ADDR_CFG_ONE, 32'd20);
        run_scan(0, 0, 1'b1);
        run_scan(0, 3, 1'b0);
        run_scan(1, 1, 1'b1);
        run_scan(0, 2, 1'b1);
        chk_div(6'd0, 4, 4);
        chk_div(6'd61, 65, 65);
        chk_div(6'h3E, 8, 24);
        chk_div(6'h3F, 8, 24);
        wr(tksc_pkg::ADDR_TRIGGER, 32'h1);
        wr(tksc_pkg::ADDR_ANA_POWER, 32'h07);
        rd_chk(tksc_pkg::ADDR_TRIGGER, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> testbench/tksc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tksc_chk #(
    parameter int MAX_COUNT_W = 16
) (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [7:0]          wb_adr_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic [31:0]         wb_dat_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    input wire logic                sense_cmp,
    input wire tksc_pkg::tksc_afe_t afe_ctrl,
    input wire logic                irq,
    input wire logic                wake_pulse
);
    // -----------------------------------------------------------------
    // Bus and scan checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Accepted writes to the trigger and interrupt registers
    wire logic trig_wr = wb_ack_o && wb_we_i && wb_adr_i == tksc_pkg::ADDR_TRIGGER && wb_sel_i[0];
    wire logic clr_wr  = wb_ack_o && wb_we_i && wb_adr_i == tksc_pkg::ADDR_IRQ_CTRL && wb_sel_i[0];
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_lat; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
    property p_abort;
        (trig_wr && !wb_dat_i[0] && afe_ctrl.scan_active) |=> !afe_ctrl.scan_active ##1 !wake_pulse;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not stop the scan");
    property p_start;
        (trig_wr && wb_dat_i[0] && afe_ctrl.front_end_on && !afe_ctrl.scan_active)
            |=> afe_ctrl.scan_active;
    endproperty
    a_start: assert property (p_start) else $error("start did not begin a scan");
    property p_wake_cause;
        wake_pulse |-> $past(afe_ctrl.scan_active) && !afe_ctrl.scan_active;
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without scan end");
    property p_wake_one; wake_pulse |=> !wake_pulse; endproperty
    a_wake_one: assert property (p_wake_one) else $error("wake longer than one cycle");
    property p_irq_clear;
        (clr_wr && wb_dat_i[tksc_pkg::POS_IRQ_CLEAR] && !afe_ctrl.scan_active) |=> !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("clear left irq high");
    property p_irq_hold; (irq && !clr_wr) |=> irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear");
    property p_off; !afe_ctrl.front_end_on |=> !afe_ctrl.scan_active; endproperty
    a_off: assert property (p_off) else $error("scan runs while module off");
    // Shortest legal half period is four reference cycles
    property p_chg;
        ($changed(afe_ctrl.charge_clk) && afe_ctrl.scan_active)
            |=> (!afe_ctrl.scan_active || $stable(afe_ctrl.charge_clk))[*3];
    endproperty
    a_chg: assert property (p_chg) else $error("charge clock half period too short");
    c_done: cover property (wake_pulse);
    c_irq: cover property ($rose(irq));
    c_abort: cover property (trig_wr && !wb_dat_i[0] && afe_ctrl.scan_active);
endmodule
bind tksc_touch_scanner tksc_chk #(.MAX_COUNT_W(MAX_COUNT_W)) u_chk (.mclk(mclk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sense_cmp(sense_cmp), .afe_ctrl(afe_ctrl), .irq(irq), .wake_pulse(wake_pulse));
`default_nettype wire

// >>> testbench/tksc_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module tksc_pad_model (
    input  wire tksc_pkg::tksc_afe_t afe_ctrl,
    input  wire logic                mclk,
    input  wire logic                touched,
    output logic                     sense_cmp
);
    // -----------------------------------------------------------------
    // Pad comparator
    // -----------------------------------------------------------------
    logic idle_ff = 1'b0;
    // Front end off: output wanders so a stale level never reads as data
    always @(posedge mclk) begin
        idle_ff <= ~idle_ff;
    end
    // One configured channel or parallel group gives one level
    assign sense_cmp = afe_ctrl.front_end_on ? touched : idle_ff;
endmodule
`default_nettype wire
